// *** sim/dsr_counter_monitor.sv ***
// port checker for the ripple counter
`timescale 1ns/1ns
module dsr_counter_monitor #(
    parameter logic [1:0] VARIANT = 2'h0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // section clock pins
    input wire logic tog_clk,
    input wire logic sec_clk,
    // clear and preset pins
    input wire logic clr_a,
    input wire logic clr_b,
    input wire logic nine_a,
    input wire logic nine_b,
    // parallel count word
    input wire logic [3:0] count
);
    wire cv = clr_a && clr_b, nv = nine_a && nine_b && !VARIANT, qt = !cv && !nv;
    wire [2:0] tp = VARIANT[1] ? 3'h7 : {2'h2, VARIANT[0]};
    wire [2:0] nx = count[3:1] == tp ? 3'h0 : count[3:1] + 3'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_sf; $fell(sec_clk) && qt ##1 qt[*2]; endsequence
    property p_clr; (cv && !nv)[*5] |-> count == 4'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_nine; nv[*5] |-> count == 4'h9; endproperty
    a_nine: assert property (p_nine) else $error("nine");
    property p_prio; (nv && cv)[*5] |-> count == 4'h9; endproperty
    a_prio: assert property (p_prio) else $error("prio");
    property p_ts; ($stable(tog_clk) && qt)[*6] |-> $stable(count[0]); endproperty
    a_ts: assert property (p_ts) else $error("bit0");
    property p_ss; ($stable(sec_clk) && qt)[*6] |-> $stable(count[3:1]); endproperty
    a_ss: assert property (p_ss) else $error("sect");
    property p_tog; $fell(tog_clk) && qt ##1 qt[*3] |-> count[0] != $past(count[0], 3);
    endproperty
    a_tog: assert property (p_tog) else $error("tog");
    property p_sec; s_sf ##1 qt[*2] |-> count[3:1] == $past(nx, 4); endproperty
    a_sec: assert property (p_sec) else $error("sec");
    property p_rip; s_sf |=> $stable(count[3:2]); endproperty
    a_rip: assert property (p_rip) else $error("rip");
endmodule
bind dsr_counter dsr_counter_monitor #(.VARIANT(VARIANT)) i_mon (.*);

// *** sim/dsr_counter_tb_top.sv ***
// random bench for the ripple counter
`timescale 1ns/1ns
module dsr_counter_tb_top;
    logic clk = 1'h0, rst = 1'h1, run, mode, clr_a, clr_b, nine_a, nine_b, tq, sq;
    wire tog_clk, sec_clk;
    wire [3:0] cnt [3];
    int seed = 25673, num_errors = 0, check_count = 0, tf = 0, sf = 0;
    initial forever #2 clk = ~clk;
    for (genvar g = 0; g < 3; g++) begin : gv
        dsr_counter #(.VARIANT(2'(g))) i_dsr_counter (.*, .count(cnt[g]));
    end
    dsr_src i_dsr_src (.*, .q0(cnt[0][0]), .q3(cnt[0][3]));
    always @(posedge clk) begin
        {tq, sq} <= {tog_clk, sec_clk};
        tf <= tf + int'(tq && !tog_clk);
        sf <= sf + int'(sq && !sec_clk);
    end
    function automatic logic [3:0] ex(int g);
        return {3'(sf % (g > 1 ? 8 : g + 5)), 1'(tf)};
    endfunction
    task automatic ck(logic [3:0] s, e);
        check_count++;
        num_errors += int'(s !== e);
        if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {run, mode, clr_a, clr_b, nine_a, nine_b} <= 6'h0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        for (int k = 0; k < 8; k++) begin
            {run, mode} <= {1'h1, 1'($random(seed))};
            repeat (6 + ($random(seed) & 63)) @(posedge clk);
            run <= 1'h0;
            repeat (20) @(posedge clk);
            for (int g = 0; g < 3; g++) ck(cnt[g], ex(g));
            $display("test %0d done", k);
        end
        clr_a <= 1'h1;
        repeat (6) @(posedge clk);
        for (int g = 0; g < 3; g++) ck(cnt[g], ex(g));
        $display("test half clear done");
        {nine_a, nine_b} <= 2'h3;
        repeat (6) @(posedge clk);
        for (int g = 0; g < 3; g++) ck(cnt[g], g ? ex(g) : 4'h9);
        $display("test nine done");
        {nine_a, nine_b, clr_b} <= 3'h1;
        repeat (6) @(posedge clk);
        for (int g = 0; g < 3; g++) ck(cnt[g], 4'h0);
        $display("test clear done");
        {nine_a, nine_b, clr_a, clr_b} <= 4'hF;
        repeat (6) @(posedge clk);
        for (int g = 0; g < 3; g++) ck(cnt[g], g ? 4'h0 : 4'h9);
        $display("test preset done");
        end_sim();
    end
endmodule

// *** sim/dsr_src.sv ***
// clock source and chaining wires at the counter pins
`timescale 1ns/1ns
module dsr_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stimulus controls
    input wire logic run,
    input wire logic mode,
    // chaining taps from the counter
    input wire logic q0,
    input wire logic q3,
    // section clock pins
    output logic tog_clk,
    output logic sec_clk
);
    logic [2:0] ph_ff;
    always_ff @(posedge clk or posedge rst)
        if (rst) ph_ff <= 3'h0;
        else if (run || ph_ff != 3'h0) ph_ff <= ph_ff == 3'h5 ? 3'h0 : ph_ff + 3'h1;
    assign tog_clk = mode ? q3 : ph_ff inside {[3'h1:3'h3]};
    assign sec_clk = mode ? ph_ff inside {[3'h1:3'h3]} : q0;
endmodule

// *** verilog/dsr_counter.sv ***
// dual section ripple counter, toggle stage plus three stage section
//
// Functional notes
// - toggle divide-by-two plus three-stage modulo-five section
// - separate section clocks, shared clear and preset
// - both clear inputs high zero all flops unless the decade preset is also high
// - both preset inputs high load nine, decade
// - twelve variant counts six, no preset
// - binary variant counts eight, no preset
// - flops change on falling section clock edge
// - later stages change after earlier, transients visible
// - all four flops presented as parallel word
`timescale 1ns/1ns
module dsr_counter #(
    parameter logic [1:0] VARIANT = dsr_pkg::VAR_DECADE
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // section clock pins
    input wire logic tog_clk,
    input wire logic sec_clk,
    // clear and preset pins, each an and pair
    input wire logic clr_a,
    input wire logic clr_b,
    input wire logic nine_a,
    input wire logic nine_b,
    // parallel count word, bit 0 is the toggle stage
    output logic [3:0] count
);
    typedef struct packed {
        logic tog_prev;
        logic sec_prev;
        logic q0;
        logic [2:0] sec;
        logic pend;
        logic [2:0] tgt;
    } dsr_state_s;

    dsr_state_s st_ff;
    dsr_state_s nxt_st;
    logic tog_s;
    logic sec_s;
    logic clr_a_s;
    logic clr_b_s;
    logic nine_a_s;
    logic nine_b_s;
    logic preset_en;
    logic [2:0] base;
    logic [2:0] top;

    // pin synchronisers
    dsr_sync u_tog (
        .clk(clk),
        .rst(rst),
        .din(tog_clk),
        .dout(tog_s)
    );
    dsr_sync u_sec (
        .clk(clk),
        .rst(rst),
        .din(sec_clk),
        .dout(sec_s)
    );
    dsr_sync u_clra (
        .clk(clk),
        .rst(rst),
        .din(clr_a),
        .dout(clr_a_s)
    );
    dsr_sync u_clrb (
        .clk(clk),
        .rst(rst),
        .din(clr_b),
        .dout(clr_b_s)
    );
    dsr_sync u_nina (
        .clk(clk),
        .rst(rst),
        .din(nine_a),
        .dout(nine_a_s)
    );
    dsr_sync u_ninb (
        .clk(clk),
        .rst(rst),
        .din(nine_b),
        .dout(nine_b_s)
    );

    // section terminal value per variant
    always_comb begin
        unique case (VARIANT)
            dsr_pkg::VAR_TWELVE: top = dsr_pkg::SEC_MOD_TWELVE - 3'h1;
            dsr_pkg::VAR_BINARY: top = dsr_pkg::SEC_TOP_BINARY;
            default: top = dsr_pkg::SEC_MOD_DECADE - 3'h1;
        endcase
    end

    assign preset_en = (VARIANT == dsr_pkg::VAR_DECADE);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tog_prev = tog_s;
        nxt_st.sec_prev = sec_s;
        base = st_ff.pend ? st_ff.tgt : st_ff.sec;
        // upper section stages follow one cycle later
        if (st_ff.pend) begin
            nxt_st.sec[2:1] = st_ff.tgt[2:1];
            nxt_st.pend = 1'b0;
        end
        // toggle stage on its own falling edge
        if (st_ff.tog_prev && !tog_s) begin
            nxt_st.q0 = ~st_ff.q0;
        end
        // section stage one first, rest ripple after
        if (st_ff.sec_prev && !sec_s) begin
            if (base == top) begin
                nxt_st.tgt = 3'h0;
            end else begin
                nxt_st.tgt = base + 3'h1;
            end
            nxt_st.sec[0] = nxt_st.tgt[0];
            nxt_st.pend = 1'b1;
        end
        // clear and preset hit both sections together
        if (preset_en && nine_a_s && nine_b_s) begin
            nxt_st.q0 = dsr_pkg::CNT_NINE[0];
            nxt_st.sec = dsr_pkg::CNT_NINE[3:1];
            nxt_st.tgt = dsr_pkg::CNT_NINE[3:1];
            nxt_st.pend = 1'b0;
        end else if (clr_a_s && clr_b_s) begin
            nxt_st.q0 = dsr_pkg::CNT_RESET[0];
            nxt_st.sec = dsr_pkg::CNT_RESET[3:1];
            nxt_st.tgt = dsr_pkg::CNT_RESET[3:1];
            nxt_st.pend = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count = {st_ff.sec, st_ff.q0};
endmodule

// *** verilog/dsr_pkg.sv ***
// constants for the dual section ripple counter
package dsr_pkg;
    localparam logic [2:0] SEC_MOD_DECADE = 3'h5;
    localparam logic [2:0] SEC_MOD_TWELVE = 3'h6;
    localparam logic [2:0] SEC_TOP_BINARY = 3'h7;
    localparam logic [1:0] VAR_DECADE = 2'h0;
    localparam logic [1:0] VAR_TWELVE = 2'h1;
    localparam logic [1:0] VAR_BINARY = 2'h2;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_NINE = 4'h9;
    localparam int SYNC_STAGES = 2;
endpackage

// *** verilog/dsr_sync.sv ***
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
module dsr_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin and synchronised level
    input wire logic din,
    output logic dout
);
    logic [dsr_pkg::SYNC_STAGES-1:0] sync_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= {sync_ff[dsr_pkg::SYNC_STAGES-2:0], din};
        end
    end

    assign dout = sync_ff[dsr_pkg::SYNC_STAGES-1];
endmodule
